// file: hdl/ten_meg_test_pattern_bist_ctrl.sv
// Test-pattern and packet self-test control with AXI4-Lite registers
// Function
// - Heartbeat disable acts only in half-duplex 10M
// - 100M or full duplex keeps heartbeat off
// - Jabber disable acts only in 10M operation
// - Error counter counts errored nibbles during self-test
// - Restarting self-test clears the error counter
// - Error counter saturates at full count
// - Continuous bit gives unbroken pseudo-random transmission while the self-test run bit is set
// - Pattern enable turns pattern generation on
// - Gap select picks 15 or 10 us
// - Selector picks data A, data B, pulses, tone
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ten_meg_cfg.svh"
module ten_meg_test_pattern_bist_ctrl #(
  parameter logic [11:0] SEQ_CYCLES = 12'(`TM_SEQ_CYC)
) (
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  speed_100,
  input  wire logic                  full_duplex,
  input  wire logic                  rx_nibble_err,
  output logic                       sqe_active_q,
  output logic                       long_tx_guard_active_q,
  output logic                       selftest_running_q,
  output logic                       selftest_tx_continuous_q,
  output logic                       pattern_burst_q,
  output ten_meg_pkg::pattern_t      pattern_kind_q,
  output logic                       irq_q
);
  localparam int GAP_SHORT_I = `TM_GAP_SHORT_CYC;
  localparam int GAP_LONG_I  = `TM_GAP_LONG_CYC;
  localparam logic [15:0] TSC_RESET_V = `TM_TSC_RESET;

  // Register state
  logic        run_q;
  logic        run_seen_q;
  logic        sqe_off_q;
  logic        guard_off_q;
  logic        rsvd_one_q;
  logic        continuous_q;
  logic        pattern_on_q;
  logic        gap_sel_q;
  logic [1:0]  choice_q;
  logic [7:0]  err_q;
  logic [2:0]  irq_stat_q;
  logic [2:0]  irq_mask_q;

  // Write channel state
  logic        aw_held_q;
  logic        w_held_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        do_write;
  logic [7:0]  wr_idx;
  logic [1:0]  wr_lo;
  logic [7:0]  rd_idx;
  logic [1:0]  rd_lo;
  logic        restart;
  logic [2:0]  irq_event;
  logic [2:0]  irq_clear;
  logic [31:0] rd_value;
  ten_meg_pkg::pattern_t seq_kind;
  logic        seq_burst;

  // Check helpers
  logic [12:0] gap_cnt_q;
  logic        gap_long_seen_q;
  logic        tone_seen_q;

  // Byte address to index and word-alignment check
  function automatic logic reg_known(input logic [7:0] idx, input logic [1:0] lo);
    reg_known = (lo == 2'b00) &&
                (idx == `TM_IDX_PHY_CONTROL || idx == `TM_IDX_TEN_MEG_STATUS ||
                 idx == `TM_IDX_PATTERN_EXT || idx == `TM_IDX_IRQ_STATUS ||
                 idx == `TM_IDX_IRQ_MASK);
  endfunction

  assign wr_idx   = {2'b00, aw_addr_q[7:2]};
  assign wr_lo    = aw_addr_q[1:0];
  assign rd_idx   = {2'b00, s_axi_araddr[7:2]};
  assign rd_lo    = s_axi_araddr[1:0];
  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

  // Address and data taken in either order
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer with an error
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TM_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= reg_known(wr_idx, wr_lo) ? `TM_RESP_OKAY : `TM_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration fields, low byte lane only holds writable bits
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run_q        <= 1'b0;
      sqe_off_q    <= 1'b0;
      guard_off_q  <= 1'b0;
      rsvd_one_q   <= TSC_RESET_V[`TM_TSC_RSVD_ONE];
      continuous_q <= 1'b0;
      pattern_on_q <= 1'b0;
      gap_sel_q    <= 1'b0;
      choice_q     <= 2'b00;
      irq_mask_q   <= 3'b000;
    end else if (do_write && wr_lo == 2'b00 && w_strb_q[0]) begin
      case (wr_idx)
        `TM_IDX_PHY_CONTROL: begin
          run_q <= w_data_q[`TM_PHYC_SELFTEST_RUN];
        end
        `TM_IDX_TEN_MEG_STATUS: begin
          sqe_off_q   <= w_data_q[`TM_TSC_SQE_OFF];
          guard_off_q <= w_data_q[`TM_TSC_LONG_TX_GUARD];
          rsvd_one_q  <= w_data_q[`TM_TSC_RSVD_ONE];
        end
        `TM_IDX_PATTERN_EXT: begin
          continuous_q <= w_data_q[`TM_PTX_CONTINUOUS];
          pattern_on_q <= w_data_q[`TM_PTX_PATTERN_ON];
          gap_sel_q    <= w_data_q[`TM_PTX_GAP_SEL];
          choice_q     <= w_data_q[`TM_PTX_CHOICE_LO +: 2];
        end
        `TM_IDX_IRQ_MASK: begin
          irq_mask_q <= w_data_q[2:0];
        end
        default: begin
          run_q <= run_q;
        end
      endcase
    end
  end

  // Start edge of the self-test run bit
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run_seen_q <= 1'b0;
    end else begin
      run_seen_q <= run_q;
    end
  end
  assign restart = run_q && !run_seen_q;

  // Saturating error counter, cleared on each restart
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      err_q <= 8'h00;
    end else if (restart) begin
      err_q <= 8'h00;
    end else if (run_q && rx_nibble_err && err_q != `TM_ERR_MAX) begin
      err_q <= err_q + 8'h01;
    end
  end

  // Sticky interrupt status; a set beats a simultaneous clear
  assign irq_event[`TM_IRQ_ERR_NIBBLE]     = run_q && rx_nibble_err && !restart;
  assign irq_event[`TM_IRQ_ERR_SATURATED]  = run_q && rx_nibble_err && !restart && err_q == 8'hFE;
  assign irq_event[`TM_IRQ_SELFTEST_START] = restart;
  assign irq_clear = (do_write && wr_idx == `TM_IDX_IRQ_STATUS && wr_lo == 2'b00 && w_strb_q[0]) ?
                     w_data_q[2:0] : 3'b000;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_q <= 3'b000;
      irq_q      <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clear) | irq_event;
      irq_q      <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Read data for a mapped index
  always_comb begin
    rd_value = 32'h0000_0000;
    case (rd_idx)
      `TM_IDX_PHY_CONTROL:    rd_value[`TM_PHYC_SELFTEST_RUN] = run_q;
      `TM_IDX_TEN_MEG_STATUS: rd_value[2:0] = {rsvd_one_q, sqe_off_q, guard_off_q};
      `TM_IDX_PATTERN_EXT:    rd_value[15:0] = {err_q, 2'b00, continuous_q, pattern_on_q,
                                                1'b0, gap_sel_q, choice_q};
      `TM_IDX_IRQ_STATUS:     rd_value[2:0] = irq_stat_q;
      `TM_IDX_IRQ_MASK:       rd_value[2:0] = irq_mask_q;
      default:                rd_value = 32'h0000_0000;
    endcase
  end

  // Read channel, one read under way at a time
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `TM_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= reg_known(rd_idx, rd_lo) ? rd_value : 32'h0000_0000;
        s_axi_rresp  <= reg_known(rd_idx, rd_lo) ? `TM_RESP_OKAY : `TM_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Line-side function enables
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sqe_active_q             <= 1'b0;
      long_tx_guard_active_q   <= 1'b0;
      selftest_running_q       <= 1'b0;
      selftest_tx_continuous_q <= 1'b0;
    end else begin
      sqe_active_q             <= !speed_100 && !full_duplex && !sqe_off_q;
      long_tx_guard_active_q   <= !speed_100 && !guard_off_q;
      selftest_running_q       <= run_q;
      selftest_tx_continuous_q <= run_q && continuous_q;
    end
  end

  // Pattern burst and gap timing
  pattern_sequencer #(
    .SEQ_CYCLES (SEQ_CYCLES),
    .GAP_SHORT  (12'(`TM_GAP_SHORT_CYC)),
    .GAP_LONG   (12'(`TM_GAP_LONG_CYC))
  ) u_seq (
    .clk     (clk),
    .arst_n  (arst_n),
    .enable  (pattern_on_q),
    .choice  (ten_meg_pkg::pattern_t'(choice_q)),
    .gap_sel (gap_sel_q),
    .burst_q (seq_burst),
    .kind_q  (seq_kind)
  );
  assign pattern_burst_q = seq_burst;
  assign pattern_kind_q  = seq_kind;

  // Gap length and mode history on the outputs, for the gap checks
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_cnt_q       <= 13'h0000;
      gap_long_seen_q <= 1'b0;
      tone_seen_q     <= 1'b0;
    end else begin
      gap_cnt_q       <= (!pattern_on_q || pattern_burst_q) ? 13'h0000 : gap_cnt_q + 13'h0001;
      gap_long_seen_q <= pattern_on_q && (gap_long_seen_q || gap_sel_q);
      tone_seen_q     <= pattern_on_q && (tone_seen_q || choice_q == 2'b11);
    end
  end

  // Checks
  AST_SQE_HALF_10M: assert property (@(posedge clk) disable iff (!arst_n)
    arst_n |=> sqe_active_q == ($past(!speed_100 && !full_duplex) && !$past(sqe_off_q)))
    else $error("heartbeat enable wrong in half-duplex 10M");
  AST_SQE_OFF_FAST: assert property (@(posedge clk) disable iff (!arst_n)
    (speed_100 || full_duplex) |=> !sqe_active_q)
    else $error("heartbeat active at 100M or full duplex");
  AST_GUARD: assert property (@(posedge clk) disable iff (!arst_n)
    (arst_n && !speed_100 && !guard_off_q) ##1 !guard_off_q |-> long_tx_guard_active_q)
    else $error("jabber guard not active");
  AST_ERR_COUNT: assert property (@(posedge clk) disable iff (!arst_n)
    (run_q && !restart && rx_nibble_err && err_q < 8'hFF) |=> err_q == $past(err_q) + 8'h01)
    else $error("error counter missed a nibble");
  AST_ERR_STILL: assert property (@(posedge clk) disable iff (!arst_n)
    (!rx_nibble_err && !restart) |=> $stable(err_q))
    else $error("error counter moved without error");
  AST_ERR_CLEAR: assert property (@(posedge clk) disable iff (!arst_n)
    restart |=> err_q == 8'h00)
    else $error("error counter not cleared on restart");
  AST_ERR_SAT: assert property (@(posedge clk) disable iff (!arst_n)
    (err_q == 8'hFF && !restart) |=> err_q == 8'hFF)
    else $error("error counter wrapped");
  AST_CONT: assert property (@(posedge clk) disable iff (!arst_n)
    (run_q && continuous_q)[*2] |-> selftest_tx_continuous_q)
    else $error("continuous transmission not held");
  AST_PAT_OFF: assert property (@(posedge clk) disable iff (!arst_n)
    !pattern_on_q [*2] |-> !pattern_burst_q && pattern_kind_q == ten_meg_pkg::PAT_DATA_EOP_A)
    else $error("pattern output while disabled");
  AST_GAP_SHORT: assert property (@(posedge clk) disable iff (!arst_n)
    (pattern_on_q && !pattern_burst_q && !gap_sel_q && !gap_long_seen_q) |-> gap_cnt_q < GAP_SHORT_I)
    else $error("short gap overrun");
  AST_GAP_END: assert property (@(posedge clk) disable iff (!arst_n)
    (pattern_on_q && !pattern_burst_q) |-> gap_cnt_q < GAP_LONG_I)
    else $error("gap longer than selected");
  AST_GAP_LEN: assert property (@(posedge clk) disable iff (!arst_n)
    (pattern_on_q && !tone_seen_q && $rose(pattern_burst_q) && gap_cnt_q > 13'h0002) |->
    (gap_cnt_q == GAP_SHORT_I || gap_cnt_q == GAP_LONG_I))
    else $error("gap length neither short nor long");
  AST_TONE: assert property (@(posedge clk) disable iff (!arst_n)
    (pattern_on_q && choice_q == 2'b11)[*4] |-> pattern_burst_q && pattern_kind_q == ten_meg_pkg::PAT_TONE)
    else $error("tone not continuous");
  AST_PAT_KIND: assert property (@(posedge clk) disable iff (!arst_n)
    pattern_on_q |=> pattern_kind_q == $past(choice_q))
    else $error("pattern kind does not follow selector");
  AST_PAT_START: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(pattern_on_q) ##1 pattern_on_q |-> ##1 pattern_burst_q)
    else $error("pattern did not start after enable");
  AST_SQE_OFF_BIT: assert property (@(posedge clk) disable iff (!arst_n)
    sqe_off_q |=> !sqe_active_q)
    else $error("heartbeat active while disabled");
  AST_GUARD_OFF: assert property (@(posedge clk) disable iff (!arst_n)
    guard_off_q |=> !long_tx_guard_active_q)
    else $error("jabber guard active while disabled");
  AST_ERR_IDLE: assert property (@(posedge clk) disable iff (!arst_n)
    !run_q |=> $stable(err_q))
    else $error("error counter moved outside self-test");
  AST_CONT_OFF: assert property (@(posedge clk) disable iff (!arst_n)
    !run_q |=> !selftest_tx_continuous_q)
    else $error("continuous transmission without self-test");
endmodule

// file: shared/ten_meg_cfg.svh
// Offsets, field positions, reset values and timing counts of the test-pattern block
`ifndef TEN_MEG_CFG_SVH
`define TEN_MEG_CFG_SVH
// Register indices; the byte address is four times the index
`define TM_IDX_PHY_CONTROL      8'h19
`define TM_IDX_TEN_MEG_STATUS   8'h1A
`define TM_IDX_PATTERN_EXT      8'h1B
`define TM_IDX_IRQ_STATUS       8'h20
`define TM_IDX_IRQ_MASK         8'h21
// Field positions
`define TM_PHYC_SELFTEST_RUN    5
`define TM_TSC_LONG_TX_GUARD    0
`define TM_TSC_SQE_OFF          1
`define TM_TSC_RSVD_ONE         2
`define TM_PTX_CHOICE_LO        0
`define TM_PTX_GAP_SEL          2
`define TM_PTX_PATTERN_ON       4
`define TM_PTX_CONTINUOUS       5
`define TM_PTX_ERR_LO           8
`define TM_IRQ_ERR_NIBBLE       0
`define TM_IRQ_ERR_SATURATED    1
`define TM_IRQ_SELFTEST_START   2
// Reset values
`define TM_TSC_RESET            16'h0004
`define TM_ERR_MAX              8'hFF
// Timing: clock period in ps, gaps in ns, cycles derived
`define TM_CLK_PERIOD_PS        4000
`define TM_GAP_SHORT_NS         10000
`define TM_GAP_LONG_NS          15000
`define TM_GAP_SHORT_CYC        ((`TM_GAP_SHORT_NS * 1000) / `TM_CLK_PERIOD_PS)
`define TM_GAP_LONG_CYC         ((`TM_GAP_LONG_NS * 1000) / `TM_CLK_PERIOD_PS)
`define TM_SEQ_CYC              100
// AXI responses
`define TM_RESP_OKAY            2'b00
`define TM_RESP_SLVERR          2'b10
`endif

// file: shared/ten_meg_pkg.sv
// Types of the test-pattern and self-test block
package ten_meg_pkg;
  typedef enum logic [1:0] {
    PAT_DATA_EOP_A = 2'b00,
    PAT_DATA_EOP_B = 2'b01,
    PAT_LINK_PULSE = 2'b10,
    PAT_TONE       = 2'b11
  } pattern_t;
  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_BURST = 2'b01,
    SEQ_GAP   = 2'b10
  } seq_state_t;
endpackage

// file: hdl/pattern_sequencer.sv
// Burst and gap sequencer for the 10 Mb/s test patterns
`timescale 1ns/1ps
`include "ten_meg_cfg.svh"
module pattern_sequencer #(
  parameter logic [11:0] SEQ_CYCLES = 12'(`TM_SEQ_CYC),
  parameter logic [11:0] GAP_SHORT  = 12'(`TM_GAP_SHORT_CYC),
  parameter logic [11:0] GAP_LONG   = 12'(`TM_GAP_LONG_CYC)
) (
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic                  enable,
  input  wire ten_meg_pkg::pattern_t choice,
  input  wire logic                  gap_sel,
  output logic                       burst_q,
  output ten_meg_pkg::pattern_t      kind_q
);
  ten_meg_pkg::seq_state_t state_q;
  logic [11:0]             count_q;

  // Burst then gap; the tone runs without gaps
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ten_meg_pkg::SEQ_IDLE;
      count_q <= 12'h000;
    end else if (!enable) begin
      state_q <= ten_meg_pkg::SEQ_IDLE;
      count_q <= 12'h000;
    end else begin
      case (state_q)
        ten_meg_pkg::SEQ_IDLE: begin
          state_q <= ten_meg_pkg::SEQ_BURST;
          count_q <= SEQ_CYCLES - 12'h001;
        end
        ten_meg_pkg::SEQ_BURST: begin
          if (choice == ten_meg_pkg::PAT_TONE) begin
            count_q <= SEQ_CYCLES - 12'h001;
          end else if (count_q == 12'h000) begin
            state_q <= ten_meg_pkg::SEQ_GAP;
            count_q <= (gap_sel ? GAP_LONG : GAP_SHORT) - 12'h001;
          end else begin
            count_q <= count_q - 12'h001;
          end
        end
        ten_meg_pkg::SEQ_GAP: begin
          if (count_q == 12'h000 || choice == ten_meg_pkg::PAT_TONE) begin
            state_q <= ten_meg_pkg::SEQ_BURST;
            count_q <= SEQ_CYCLES - 12'h001;
          end else begin
            count_q <= count_q - 12'h001;
          end
        end
        default: begin
          state_q <= ten_meg_pkg::SEQ_IDLE;
          count_q <= 12'h000;
        end
      endcase
    end
  end

  // Registered pattern outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      burst_q <= 1'b0;
      kind_q  <= ten_meg_pkg::PAT_DATA_EOP_A;
    end else begin
      burst_q <= enable && (state_q == ten_meg_pkg::SEQ_BURST);
      kind_q  <= enable ? choice : ten_meg_pkg::PAT_DATA_EOP_A;
    end
  end
endmodule

// file: verification/line_partner.sv
// Line-side test equipment model reporting errored nibbles
`timescale 1ns/1ps
module line_partner (
  input  wire logic clk,
  output logic      rx_nibble_err
);
  initial rx_nibble_err = 1'b0;

  // One pulse per errored nibble; space 0 gives back-to-back errors
  task automatic send_errs(input int n, input int space);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rx_nibble_err <= 1'b1;
      repeat (space) begin
        @(posedge clk);
        rx_nibble_err <= 1'b0;
      end
    end
    @(posedge clk);
    rx_nibble_err <= 1'b0;
  endtask
endmodule

// file: verification/testbench.sv
// Self-checking bench of the test-pattern and self-test control block
`timescale 1ns/1ps
`include "ten_meg_cfg.svh"
module testbench;
  localparam logic [7:0] A_PHY = 8'(`TM_IDX_PHY_CONTROL * 4);
  localparam logic [7:0] A_TSC = 8'(`TM_IDX_TEN_MEG_STATUS * 4);
  localparam logic [7:0] A_PTX = 8'(`TM_IDX_PATTERN_EXT * 4);
  localparam logic [7:0] A_IST = 8'(`TM_IDX_IRQ_STATUS * 4);
  localparam logic [7:0] A_IMK = 8'(`TM_IDX_IRQ_MASK * 4);
  localparam logic [1:0] OK    = `TM_RESP_OKAY;
  localparam logic [1:0] ERR   = `TM_RESP_SLVERR;
  localparam int         SEQ   = 4;
  logic clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, speed_100, full_duplex, rx_nibble_err;
  logic sqe_active_q, long_tx_guard_active_q, selftest_running_q, selftest_tx_continuous_q;
  logic pattern_burst_q, irq_q;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  ten_meg_pkg::pattern_t pattern_kind_q;
  int error_cnt, checked;

`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[FAIL] %0t mismatch got %0h exp %0h", $time, (got), (exp)); end end

  // Clock and device under test
  initial clk = 1'b0;
  always #2 clk = ~clk;
  ten_meg_test_pattern_bist_ctrl #(.SEQ_CYCLES(12'h004)) dut (
    .clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .speed_100, .full_duplex, .rx_nibble_err, .sqe_active_q, .long_tx_guard_active_q,
    .selftest_running_q, .selftest_tx_continuous_q, .pattern_burst_q, .pattern_kind_q, .irq_q);
  line_partner p (.clk(clk), .rx_nibble_err(rx_nibble_err));

  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Bus write; address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic [1:0] r;
    n = 0;
    r = 2'b11;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) r = s_axi_bresp;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    s_axi_bready <= 1'b0;
    `CHK(r, er)
  endtask

  // Bus read; rready held until the answer is sampled
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int n;
    logic [1:0] r;
    n = 0;
    r = 2'b11;
    d = 32'hdead_beef;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) r = s_axi_rresp;
      if (s_axi_rvalid) d = s_axi_rdata;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    s_axi_rready <= 1'b0;
    `CHK(r, er)
  endtask

  // Reset values, unmapped and misaligned accesses
  task automatic t_reset_map();
    rd(A_TSC, rdat, OK);
    `CHK(rdat, 32'h0000_0004)
    rd(A_PTX, rdat, OK);
    `CHK(rdat, 32'h0000_0000)
    rd(8'h70, rdat, ERR);
    `CHK(rdat, 32'h0000_0000)
    wr(8'h70, 32'h0000_00ff, ERR);
    wr(A_PHY + 8'h01, 32'h0000_0020, ERR);
    rd(A_PHY, rdat, OK);
    `CHK(rdat, 32'h0000_0000)
    `CHK(sqe_active_q, 1'b1)
  endtask

  // Heartbeat and jabber enables over all speed, duplex and control mixes
  task automatic t_link_modes();
    for (int i = 0; i < 16; i++) begin
      speed_100 <= i[0];
      full_duplex <= i[1];
      wr(A_TSC, {29'h0, 1'b1, i[2], i[3]}, OK);
      repeat (2) @(posedge clk);
      `CHK(sqe_active_q, !i[0] && !i[1] && !i[2])
      `CHK(long_tx_guard_active_q, !i[0] && !i[3])
    end
    rd(A_TSC, rdat, OK);
    `CHK(rdat, 32'h0000_0007)
    speed_100 <= 1'b0;
    full_duplex <= 1'b0;
  endtask

  // Length of the next burst and of the gap after it
  task automatic measure(input int cap, output int hi, output int lo, output ten_meg_pkg::pattern_t k);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pattern_burst_q !== 1'b1 && n < 50);
    k = pattern_kind_q;
    hi = 0;
    while (pattern_burst_q === 1'b1 && hi < cap) begin
      hi++;
      @(posedge clk);
    end
    lo = 0;
    while (pattern_burst_q !== 1'b1 && lo < 5000) begin
      lo++;
      @(posedge clk);
    end
  endtask

  // Pattern selector, gap lengths and enable
  task automatic t_pattern();
    int hi, lo;
    ten_meg_pkg::pattern_t k;
    wr(A_PTX, 32'h0000_0007, OK);
    repeat (20) @(posedge clk);
    `CHK(pattern_burst_q, 1'b0)
    `CHK(pattern_kind_q, ten_meg_pkg::PAT_DATA_EOP_A)
    for (int c = 0; c < 4; c++) begin
      wr(A_PTX, 32'(16 + c + ((c == 1) ? 4 : 0)), OK);
      measure(200, hi, lo, k);
      `CHK(k, ten_meg_pkg::pattern_t'(c))
      if (c < 3) begin
        `CHK(hi, SEQ)
        `CHK(lo, (c == 1) ? `TM_GAP_LONG_CYC : `TM_GAP_SHORT_CYC)
      end else begin
        `CHK(hi, 200)
      end
      wr(A_PTX, 32'h0000_0000, OK);
      repeat (2) @(posedge clk);
      `CHK(pattern_burst_q, 1'b0)
    end
  endtask

  // Error counter, saturation, restart and interrupts
  task automatic t_selftest();
    wr(A_PHY, 32'h0000_0020, OK);
    repeat (2) @(posedge clk);
    `CHK(selftest_running_q, 1'b1)
    p.send_errs(5, 0);
    rd(A_PTX, rdat, OK);
    `CHK(rdat[15:8], 8'h05)
    p.send_errs(260, 2);
    rd(A_PTX, rdat, OK);
    `CHK(rdat[15:8], 8'hff)
    rd(A_IST, rdat, OK);
    `CHK(rdat, 32'h0000_0007)
    `CHK(irq_q, 1'b0)
    wr(A_IMK, 32'h0000_0002, OK);
    repeat (2) @(posedge clk);
    `CHK(irq_q, 1'b1)
    wr(A_IST, 32'h0000_0007, OK);
    repeat (2) @(posedge clk);
    `CHK(irq_q, 1'b0)
    wr(A_PHY, 32'h0000_0000, OK);
    wr(A_PHY, 32'h0000_0020, OK);
    rd(A_PTX, rdat, OK);
    `CHK(rdat[15:8], 8'h00)
    wr(A_PHY, 32'h0000_0000, OK);
    p.send_errs(3, 1);
    rd(A_PTX, rdat, OK);
    `CHK(rdat[15:8], 8'h00)
  endtask

  // Continuous transmission needs the self-test run bit as well
  task automatic t_continuous();
    wr(A_TSC, 32'h0000_0005, OK);
    wr(A_PTX, 32'h0000_0020, OK);
    repeat (2) @(posedge clk);
    `CHK(selftest_tx_continuous_q, 1'b0)
    wr(A_PHY, 32'h0000_0020, OK);
    repeat (2) @(posedge clk);
    `CHK(selftest_tx_continuous_q, 1'b1)
    `CHK(long_tx_guard_active_q, 1'b0)
    wr(A_PHY, 32'h0000_0000, OK);
    repeat (2) @(posedge clk);
    `CHK(selftest_tx_continuous_q, 1'b0)
  endtask

  // Main sequence
  initial begin
    {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {speed_100, full_duplex, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'h1;
    error_cnt = 0;
    checked = 0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    t_reset_map();
    t_link_modes();
    t_pattern();
    t_selftest();
    t_continuous();
    end_sim();
  end

  // Watchdog against a hang
  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end
endmodule
